//--- decoder_defines.vh
`ifndef MCU_DECODER_DEFINES_VH
`define MCU_DECODER_DEFINES_VH

// Register map, byte addresses on the APB word grid
`define REG_CTRL      8'h00
`define REG_STAT      8'h04
`define REG_WREG      8'h08
`define REG_PC        8'h0c
`define REG_INSTR     8'h10

// Control register fields
`define CTRL_RUN      0
`define CTRL_WAKE     1

// Status register fields
`define ST_C          0
`define ST_DC         1
`define ST_Z          2
`define ST_PD         3
`define ST_TO         4
`define ST_STBY       5

// Instruction word fields
`define IW_W          14
`define F_GRP         13:12
`define F_OP          11:8
`define F_BOP         11:10
`define F_BIT         9:7
`define F_D           7
`define F_ADDR        6:0
`define F_K8          7:0
`define F_K11         10:0
`define F_CALLJMP     11
`define F_LOW         7:0

// Instruction groups
`define GRP_BYTE      2'b00
`define GRP_BIT       2'b01
`define GRP_CTL       2'b10
`define GRP_LIT       2'b11

// Byte-oriented operation codes
`define OP_MISC       4'h0
`define OP_CLR        4'h1
`define OP_SUB        4'h2
`define OP_DEC        4'h3
`define OP_OR         4'h4
`define OP_AND        4'h5
`define OP_XOR        4'h6
`define OP_ADD        4'h7
`define OP_MOV        4'h8
`define OP_COM        4'h9
`define OP_INC        4'ha
`define OP_DECSZ      4'hb
`define OP_RRC        4'hc
`define OP_RLC        4'hd
`define OP_SWAP       4'he
`define OP_INCSZ      4'hf

// Bit-oriented sub-operations
`define BOP_CLR       2'b00
`define BOP_SET       2'b01
`define BOP_TSTC      2'b10
`define BOP_TSTS      2'b11

// Literal group codes (casez patterns)
`define LIT_LOAD      4'b00??
`define LIT_RET       4'b01??
`define LIT_OR        4'b1000
`define LIT_AND       4'b1001
`define LIT_XOR       4'b1010
`define LIT_SUB       4'b110?
`define LIT_ADD       4'b111?

// Low bytes of the miscellaneous control words
`define MISC_RET      8'h08
`define MISC_RETI     8'h09
`define MISC_SLEEP    8'h63
`define MISC_WDT      8'h64

`endif

//--- mcu_decoder.v
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`include "decoder_defines.vh"

// Overview of operation
// - Fetch and decode one 14-bit word
// - Destination bit picks W or file
// - File address is low seven bits
// - Three-bit field selects one file bit
// - 8-bit literals; call/jump 11-bit, two cycles
// - Instruction cycle is four oscillator periods
// - One cycle; skips and branches take two
// - File operands always read; stored only when the file is the destination
// - Don't-care bits never change decoding
// - Byte group arithmetic and logic codes
// - Flag update per operation; clear, store W
// - Inc/dec skip on zero, flags untouched
// - Rotates through carry, only carry changes
// - Bit clear, set, skip if clear
// - Bit test skips when bit set
// - Literal add and subtract update three flags
// - Literal and/or/xor update only zero
// - Returns load PC from stack, two cycles
// - Standby and watchdog clear update status bits
// - Port read-modify uses pin levels
module mcu_decoder
#(
  parameter PC_W        = 11,
  parameter STACK_DEPTH = 8,
  parameter SP_W        = 3,
  parameter OSC_DIV     = 1,
  parameter DIV_W       = 4,
  parameter [6:0] PORT_ADDR = 7'h05
)
(
  input  wire              core_clk,   // 200 MHz core clock
  input  wire              rstn,       // Async reset, active low
  input  wire              psel,       // APB select
  input  wire              penable,    // APB enable
  input  wire              pwrite,     // APB write
  input  wire [7:0]        paddr,      // APB byte address
  input  wire [31:0]       pwdata,     // APB write data
  output wire [31:0]       prdata,     // APB read data
  output wire              pready,     // APB ready
  output wire              pslverr,    // APB error, unmapped address
  output wire [PC_W-1:0]   pmem_addr,  // Program memory address
  input  wire [`IW_W-1:0]  pmem_data,  // Program memory word
  output wire [6:0]        fr_addr,    // File register address
  output wire              fr_re,      // File read strobe
  input  wire [7:0]        fr_rdata,   // File read data
  output wire              fr_we,      // File write strobe
  output wire [7:0]        fr_wdata,   // File write data
  input  wire [7:0]        port_pins,  // Port pin levels, asynchronous
  output wire              standby,    // Core in standby
  output wire              wdt_clear   // Watchdog clear pulse
);

  localparam [3:0] PH_Q1 = 4'b0001;
  localparam [3:0] PH_Q2 = 4'b0010;
  localparam [3:0] PH_Q3 = 4'b0100;
  localparam [3:0] PH_Q4 = 4'b1000;

  reg  [3:0]        ph_r;
  reg  [DIV_W-1:0]  div_r;
  reg               osc_en;
  reg  [PC_W-1:0]   pc_r;
  reg  [PC_W-1:0]   pmem_addr_r;
  reg  [`IW_W-1:0]  ir_r;
  reg  [7:0]        w_r;
  reg  [7:0]        opnd_r;
  reg               c_r;
  reg               dc_r;
  reg               z_r;
  reg               to_r;
  reg               pd_r;
  reg               stby_r;
  reg               run_r;
  reg               squash_r;
  reg               hold_r;
  reg               rd_pend_r;
  reg               port_rd_r;
  reg  [6:0]        fr_addr_r;
  reg               fr_re_r;
  reg               fr_we_r;
  reg  [7:0]        fr_wdata_r;
  reg               wdt_clear_r;
  reg  [7:0]        pin_s1_r;
  reg  [7:0]        pin_s2_r;
  reg  [31:0]       prdata_r;
  reg               pready_r;
  reg               pslverr_r;
  reg  [PC_W-1:0]   stack_r [0:STACK_DEPTH-1];
  reg  [SP_W-1:0]   sp_r;

  wire [1:0]  grp = ir_r[`F_GRP];
  wire [3:0]  op  = ir_r[`F_OP];
  wire [7:0]  k8  = ir_r[`F_K8];
  wire        d   = ir_r[`F_D];
  // At OSC_DIV of 1 the operand lands on the execute edge, so execution reads it directly
  wire [7:0]  opnd = rd_pend_r ? (port_rd_r ? pin_s2_r : fr_rdata) :
                     opnd_r;
  wire        active = run_r & ~stby_r;
  wire        dead   = squash_r | hold_r;
  wire [PC_W-1:0] pc_inc   = pc_r + {{(PC_W-1){1'b0}}, 1'b1};
  wire [SP_W-1:0] sp_dec   = sp_r - {{(SP_W-1){1'b0}}, 1'b1};
  wire [PC_W-1:0] stack_top = stack_r[sp_dec];
  wire [1:0]  fgrp = pmem_data[`F_GRP];
  wire [3:0]  fop  = pmem_data[`F_OP];
  // Clear-W and the misc words name no file register
  wire        file_op = (fgrp == `GRP_BIT) |
                        ((fgrp == `GRP_BYTE) &
                         ~(((fop == `OP_MISC) | (fop == `OP_CLR)) &
                           ~pmem_data[`F_D]));
  wire        apb_acc = psel & penable & pready_r;
  wire        apb_wr  = apb_acc & pwrite;

  reg  [7:0]      src;
  reg  [7:0]      res;
  reg  [7:0]      mask;
  reg  [8:0]      sum;
  reg  [4:0]      hsum;
  reg             sub;
  reg             use_d;
  reg             wr_w;
  reg             wr_f;
  reg             upd_z;
  reg             upd_c;
  reg             upd_dc;
  reg             c_n;
  reg             dc_n;
  reg             skip_n;
  reg             hold_n;
  reg  [PC_W-1:0] pc_n;
  reg             push;
  reg             pop;
  reg             sleep_n;
  reg             wdt_n;

  always @*
  begin
    src  = (grp == `GRP_LIT) ? k8 : opnd;
    sub  = ((grp == `GRP_BYTE) & (op == `OP_SUB)) |
           ((grp == `GRP_LIT) & (op[3:1] == 3'b110));
    // Subtraction adds the complement plus one, so carry means no borrow
    sum  = {1'b0, src} + {1'b0, (sub ? ~w_r : w_r)} + {8'h00, sub};
    hsum = {1'b0, src[3:0]} + {1'b0, (sub ? ~w_r[3:0] : w_r[3:0])} +
           {4'h0, sub};
    mask    = 8'h01 << ir_r[`F_BIT];
    res     = opnd;
    use_d   = 1'b0;
    wr_w    = 1'b0;
    wr_f    = 1'b0;
    upd_z   = 1'b0;
    upd_c   = 1'b0;
    upd_dc  = 1'b0;
    c_n     = c_r;
    dc_n    = dc_r;
    skip_n  = 1'b0;
    hold_n  = 1'b0;
    pc_n    = pc_inc;
    push    = 1'b0;
    pop     = 1'b0;
    sleep_n = 1'b0;
    wdt_n   = 1'b0;
    case (grp)
      `GRP_BYTE:
      begin
        case (op)
          `OP_MISC:
          begin
            if (d)
            begin
              res  = w_r;
              wr_f = 1'b1;
            end
            else
            begin
              case (ir_r[`F_LOW])
                `MISC_RET, `MISC_RETI:
                begin
                  pop    = 1'b1;
                  hold_n = 1'b1;
                  pc_n   = stack_top;
                end
                `MISC_SLEEP: sleep_n = 1'b1;
                `MISC_WDT:   wdt_n   = 1'b1;
                default:     pc_n    = pc_inc;
              endcase
            end
          end
          `OP_CLR:
          begin
            res   = 8'h00;
            upd_z = 1'b1;
            use_d = 1'b1;
          end
          `OP_SUB, `OP_ADD:
          begin
            res    = sum[7:0];
            c_n    = sum[8];
            dc_n   = hsum[4];
            upd_c  = 1'b1;
            upd_dc = 1'b1;
            upd_z  = 1'b1;
            use_d  = 1'b1;
          end
          `OP_AND, `OP_OR, `OP_XOR, `OP_MOV, `OP_COM, `OP_DEC, `OP_INC:
          begin
            case (op)
              `OP_AND: res = w_r & opnd;
              `OP_OR:  res = w_r | opnd;
              `OP_XOR: res = w_r ^ opnd;
              `OP_COM: res = ~opnd;
              `OP_DEC: res = opnd - 8'h01;
              `OP_INC: res = opnd + 8'h01;
              default: res = opnd;
            endcase
            upd_z = 1'b1;
            use_d = 1'b1;
          end
          `OP_DECSZ, `OP_INCSZ:
          begin
            res    = (op == `OP_INCSZ) ? opnd + 8'h01 : opnd - 8'h01;
            skip_n = (res == 8'h00);
            use_d  = 1'b1;
          end
          `OP_RRC:
          begin
            res   = {c_r, opnd[7:1]};
            c_n   = opnd[0];
            upd_c = 1'b1;
            use_d = 1'b1;
          end
          `OP_RLC:
          begin
            res   = {opnd[6:0], c_r};
            c_n   = opnd[7];
            upd_c = 1'b1;
            use_d = 1'b1;
          end
          default:
          begin
            res   = {opnd[3:0], opnd[7:4]};
            use_d = 1'b1;
          end
        endcase
        if (use_d)
        begin
          wr_f = d;
          wr_w = ~d;
        end
      end
      `GRP_BIT:
      begin
        case (ir_r[`F_BOP])
          `BOP_CLR:
          begin
            res  = opnd & ~mask;
            wr_f = 1'b1;
          end
          `BOP_SET:
          begin
            res  = opnd | mask;
            wr_f = 1'b1;
          end
          `BOP_TSTC: skip_n = ~|(opnd & mask);
          default:   skip_n = |(opnd & mask);
        endcase
      end
      `GRP_CTL:
      begin
        pc_n   = ir_r[`F_K11];
        hold_n = 1'b1;
        push   = ~ir_r[`F_CALLJMP];
      end
      default:
      begin
        casez (op)
          `LIT_LOAD:
          begin
            res  = k8;
            wr_w = 1'b1;
          end
          `LIT_RET:
          begin
            res    = k8;
            wr_w   = 1'b1;
            pop    = 1'b1;
            hold_n = 1'b1;
            pc_n   = stack_top;
          end
          `LIT_OR, `LIT_AND, `LIT_XOR:
          begin
            res   = (op == `LIT_OR)  ? (w_r | k8) :
                    (op == `LIT_AND) ? (w_r & k8) : (w_r ^ k8);
            wr_w  = 1'b1;
            upd_z = 1'b1;
          end
          `LIT_SUB, `LIT_ADD:
          begin
            res    = sum[7:0];
            c_n    = sum[8];
            dc_n   = hsum[4];
            wr_w   = 1'b1;
            upd_c  = 1'b1;
            upd_dc = 1'b1;
            upd_z  = 1'b1;
          end
          default: wr_w = 1'b0;
        endcase
      end
    endcase
  end

  // Oscillator period enable; one period per phase
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      div_r  <= {DIV_W{1'b0}};
      osc_en <= 1'b0;
    end
    else if (div_r == OSC_DIV[DIV_W-1:0] - {{(DIV_W-1){1'b0}}, 1'b1})
    begin
      div_r  <= {DIV_W{1'b0}};
      osc_en <= 1'b1;
    end
    else
    begin
      div_r  <= div_r + {{(DIV_W-1){1'b0}}, 1'b1};
      osc_en <= 1'b0;
    end
  end

  // Pins are foreign to this clock, so they pass two flops first
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pin_s1_r <= 8'h00;
      pin_s2_r <= 8'h00;
    end
    else
    begin
      pin_s1_r <= port_pins;
      pin_s2_r <= pin_s1_r;
    end
  end

  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ph_r        <= PH_Q1;
      pc_r        <= {PC_W{1'b0}};
      pmem_addr_r <= {PC_W{1'b0}};
      ir_r        <= {`IW_W{1'b0}};
      w_r         <= 8'h00;
      opnd_r      <= 8'h00;
      c_r         <= 1'b0;
      dc_r        <= 1'b0;
      z_r         <= 1'b0;
      to_r        <= 1'b1;
      pd_r        <= 1'b1;
      stby_r      <= 1'b0;
      squash_r    <= 1'b0;
      hold_r      <= 1'b0;
      rd_pend_r   <= 1'b0;
      port_rd_r   <= 1'b0;
      fr_addr_r   <= 7'h00;
      fr_re_r     <= 1'b0;
      fr_we_r     <= 1'b0;
      fr_wdata_r  <= 8'h00;
      wdt_clear_r <= 1'b0;
      sp_r        <= {SP_W{1'b0}};
    end
    else
    begin
      fr_re_r     <= 1'b0;
      fr_we_r     <= 1'b0;
      wdt_clear_r <= 1'b0;
      rd_pend_r   <= fr_re_r;
      if (rd_pend_r)
        opnd_r <= port_rd_r ? pin_s2_r : fr_rdata;
      if (apb_wr && (paddr == `REG_CTRL) && pwdata[`CTRL_WAKE])
        stby_r <= 1'b0;
      if (osc_en && active)
      begin
        case (ph_r)
          PH_Q1:
          begin
            pmem_addr_r <= pc_r;
            ph_r        <= PH_Q2;
          end
          PH_Q2:
          begin
            ir_r      <= pmem_data;
            fr_addr_r <= pmem_data[`F_ADDR];
            port_rd_r <= (pmem_data[`F_ADDR] == PORT_ADDR);
            fr_re_r   <= file_op & ~dead;
            ph_r      <= PH_Q3;
          end
          PH_Q3:
            ph_r <= PH_Q4;
          PH_Q4:
          begin
            ph_r <= PH_Q1;
            if (dead)
            begin
              // Second cycle of a two-cycle instruction runs as a no-op
              squash_r <= 1'b0;
              hold_r   <= 1'b0;
              if (squash_r)
                pc_r <= pc_inc;
            end
            else
            begin
              pc_r     <= pc_n;
              squash_r <= skip_n;
              hold_r   <= hold_n;
              if (wr_w)
                w_r <= res;
              if (wr_f)
              begin
                fr_we_r    <= 1'b1;
                fr_wdata_r <= res;
              end
              if (upd_z)
                z_r <= (res == 8'h00);
              if (upd_c)
                c_r <= c_n;
              if (upd_dc)
                dc_r <= dc_n;
              if (push)
              begin
                stack_r[sp_r] <= pc_inc;
                sp_r          <= sp_r + {{(SP_W-1){1'b0}}, 1'b1};
              end
              if (pop)
                sp_r <= sp_dec;
              if (sleep_n)
              begin
                // Entering standby wins over a wake write in this cycle
                stby_r <= 1'b1;
                to_r   <= 1'b1;
                pd_r   <= 1'b0;
              end
              if (wdt_n)
              begin
                wdt_clear_r <= 1'b1;
                to_r        <= 1'b1;
                pd_r        <= 1'b1;
              end
            end
          end
          default:
            ph_r <= PH_Q1;
        endcase
      end
    end
  end

  // APB slave: data set up in the setup cycle, zero wait states
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      run_r     <= 1'b0;
    end
    else
    begin
      pready_r  <= psel & ~penable;
      if (psel && !penable)
      begin
        pslverr_r <= 1'b0;
        prdata_r  <= 32'h0000_0000;
        case (paddr)
          `REG_CTRL:  prdata_r[`CTRL_RUN] <= run_r;
          `REG_STAT:
          begin
            prdata_r[`ST_C]    <= c_r;
            prdata_r[`ST_DC]   <= dc_r;
            prdata_r[`ST_Z]    <= z_r;
            prdata_r[`ST_PD]   <= pd_r;
            prdata_r[`ST_TO]   <= to_r;
            prdata_r[`ST_STBY] <= stby_r;
          end
          `REG_WREG:  prdata_r[7:0] <= w_r;
          `REG_PC:    prdata_r[PC_W-1:0] <= pc_r;
          `REG_INSTR: prdata_r[`IW_W-1:0] <= ir_r;
          default:    pslverr_r <= 1'b1;
        endcase
      end
      if (apb_wr && (paddr == `REG_CTRL))
        run_r <= pwdata[`CTRL_RUN];
    end
  end

  assign prdata    = prdata_r;
  assign pready    = pready_r;
  assign pslverr   = pslverr_r;
  assign pmem_addr = pmem_addr_r;
  assign fr_addr   = fr_addr_r;
  assign fr_re     = fr_re_r;
  assign fr_we     = fr_we_r;
  assign fr_wdata  = fr_wdata_r;
  assign standby   = stby_r;
  assign wdt_clear = wdt_clear_r;

endmodule

//--- prog_file_model.sv
`timescale 1ns/1ps
module prog_file_model
(
  input  wire        core_clk,   // Core clock
  input  wire [10:0] pmem_addr,  // Fetch address
  output wire [13:0] pmem_data,  // Instruction word
  input  wire [6:0]  fr_addr,    // File address
  input  wire        fr_re,      // File read strobe
  output logic [7:0] fr_rdata,   // File read data
  input  wire        fr_we,      // File write strobe
  input  wire [7:0]  fr_wdata    // File write data
);
  logic [13:0] rom [0:2047];
  logic [7:0]  ram [0:127];

  initial
    fr_rdata = 8'h5a;

  assign pmem_data = rom[pmem_addr];

  // Data lives one clock, then toggles so a late sample shows up
  always @(posedge core_clk)
  begin
    fr_rdata <= fr_re ? ram[fr_addr] : ~fr_rdata;
    if (fr_we)
      ram[fr_addr] <= fr_wdata;
  end
endmodule

//--- mcu_decoder_checker.sv
`timescale 1ns/1ps
`include "decoder_defines.vh"
module mcu_decoder_checker
#(
  parameter PC_W = 11
)
(
  input wire             core_clk,   // Core clock
  input wire             rstn,       // Reset, active low
  input wire             psel,       // APB select
  input wire             penable,    // APB enable
  input wire             pwrite,     // APB write
  input wire [7:0]       paddr,      // APB address
  input wire [31:0]      pwdata,     // APB write data
  input wire [31:0]      prdata,     // APB read data
  input wire             pready,     // APB ready
  input wire             pslverr,    // APB error
  input wire [PC_W-1:0]  pmem_addr,  // Fetch address
  input wire [`IW_W-1:0] pmem_data,  // Instruction word
  input wire [6:0]       fr_addr,    // File address
  input wire             fr_re,      // File read strobe
  input wire [7:0]       fr_rdata,   // File read data
  input wire             fr_we,      // File write strobe
  input wire [7:0]       fr_wdata,   // File write data
  input wire [7:0]       port_pins,  // Pin levels
  input wire             standby,    // Standby level
  input wire             wdt_clear   // Watchdog clear pulse
);
  wire wake_wr;

  assign wake_wr = psel && penable && pready && pwrite &&
                   paddr == `REG_CTRL && pwdata[`CTRL_WAKE];

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  sequence s_setup;
    psel && !penable;
  endsequence

  sequence s_unmapped;
    s_setup ##0 !(paddr inside {`REG_CTRL, `REG_STAT, `REG_WREG, `REG_PC,
                                `REG_INSTR});
  endsequence

  a_ready_after_setup: assert property (s_setup |=> pready)
    else $error("pready missing after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_unmapped_error: assert property
    (s_unmapped |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_mapped_no_error: assert property
    (s_setup ##0 (paddr inside {`REG_CTRL, `REG_STAT, `REG_WREG, `REG_PC,
                                `REG_INSTR}) |=> !pslverr)
    else $error("mapped access refused");
  a_read_first: assert property (fr_we |-> $past(fr_re, 2) || $past(fr_re, 3))
    else $error("file write without prior read");
  a_read_spacing: assert property (fr_re |=> !fr_re [*3])
    else $error("file reads closer than four clocks");
  a_write_spacing: assert property (fr_we |=> !fr_we [*3])
    else $error("file writes closer than four clocks");
  a_addr_held: assert property (fr_re |=> $stable(fr_addr) [*3])
    else $error("file address moved mid cycle");
  a_fetch_held: assert property
    ($changed(pmem_addr) |=> $stable(pmem_addr) [*3])
    else $error("fetch address moved mid cycle");
  a_wdt_pulse: assert property (wdt_clear |=> !wdt_clear)
    else $error("watchdog clear longer than one clock");
  a_standby_halts: assert property
    (standby && !wake_wr |=> standby && !fr_re && !fr_we)
    else $error("standby left or core active");
endmodule

bind mcu_decoder mcu_decoder_checker #(.PC_W(PC_W)) chk_i
  (.core_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
   .pready, .pslverr, .pmem_addr, .pmem_data, .fr_addr, .fr_re,
   .fr_rdata, .fr_we, .fr_wdata, .port_pins, .standby, .wdt_clear);

//--- test_mcu_decoder.sv
`timescale 1ns/1ps
`include "decoder_defines.vh"
`define CHK(a, e) \
  begin \
    samples_checked++; \
    if ((a) !== (e)) \
    begin \
      fail_count++; \
      $display("Error at %0t: got %h, expected %h", $time, a, e); \
    end \
  end
module test_mcu_decoder;
  localparam logic [13:0] prog [0:22] = '{14'h300f, 14'h07a0, 14'h0221,
    14'h13a1, 14'h1fa1, 14'h0bff, 14'h30aa, 14'h0da0, 14'h3af0, 14'h0064,
    14'h280c, 14'h1020, 14'h0e05, 14'h0063, 14'h3005, 14'h3c03, 14'h2016,
    14'h01a1, 14'h1821, 14'h1421, 14'h15a1, 14'h0063, 14'h3481};
  localparam logic [5:0] ops [0:4] = '{6'h39, 6'h38, 6'h3a, 6'h3f, 6'h3d};
  logic        core_clk, rstn, psel, penable, pwrite;
  logic [7:0]  paddr, port_pins;
  logic [31:0] pwdata;
  wire  [31:0] prdata;
  wire         pready, pslverr, fr_re, fr_we, standby, wdt_clear;
  wire  [10:0] pmem_addr;
  wire  [13:0] pmem_data;
  wire  [6:0]  fr_addr;
  wire  [7:0]  fr_rdata, fr_wdata;
  int          fail_count, samples_checked;
  logic [32:0] expq [$];
  logic [32:0] exp_v;
  logic [15:0] lfsr_r = 16'h001b;

  mcu_decoder mcu_decoder_i (.core_clk, .rstn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .pmem_addr, .pmem_data,
    .fr_addr, .fr_re, .fr_rdata, .fr_we, .fr_wdata, .port_pins, .standby,
    .wdt_clear);
  prog_file_model prog_file_model_i (.core_clk, .pmem_addr, .pmem_data,
    .fr_addr, .fr_re, .fr_rdata, .fr_we, .fr_wdata);

  function automatic logic [7:0] rnd();
    lfsr_r = {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
    return lfsr_r[7:0];
  endfunction

  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Reads note their expected {pslverr, prdata} for the monitor
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [32:0] e);
    int n;
    n = 0;
    if (!w)
      expq.push_back(e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
      fail_count++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic wait_sb();
    int n;
    n = 0;
    while (standby !== 1'b1 && n < 500)
    begin
      @(posedge core_clk);
      n++;
    end
    `CHK(standby, 1'b1)
  endtask

  always @(posedge core_clk)
    if (psel && penable && pready === 1'b1 && !pwrite)
    begin
      exp_v = expq.pop_front();
      `CHK({pslverr, prdata}, exp_v)
    end

  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  initial
  begin
    #60000;
    fail_count++;
    print_verdict();
  end

  initial
  begin
    logic [7:0] a, k, r;
    logic       c, dc;
    int         pc;
    c = 1'b0;
    dc = 1'b0;
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    port_pins = rnd();
    foreach (prog[i])
      prog_file_model_i.rom[i] = prog[i];
    prog_file_model_i.ram[7'h20] = 8'h3c;
    prog_file_model_i.ram[7'h21] = 8'hff;
    prog_file_model_i.ram[7'h7f] = 8'h01;
    // Latch differs from pins so a latch read is caught
    prog_file_model_i.ram[7'h05] = ~port_pins;
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    apb(1'b1, `REG_CTRL, 32'h1, 33'h0);
    wait_sb();
    apb(1'b1, `REG_STAT, 32'hff, 33'h0);
    apb(0, `REG_STAT, 0, 33'h36);
    apb(0, `REG_WREG, 0, {25'h0, port_pins[3:0], port_pins[7:4]});
    apb(0, `REG_PC, 0, 33'd14);
    apb(0, `REG_INSTR, 0, 33'h63);
    apb(0, 8'h14, 0, {1'b1, 32'h0});
    `CHK(prog_file_model_i.ram[7'h20], 8'h97)
    `CHK(prog_file_model_i.ram[7'h21], 8'h7f)
    `CHK(prog_file_model_i.ram[7'h7f], 8'h00)
    `CHK(prog_file_model_i.ram[7'h05], ~port_pins)
    $display("Test byte and skip ops done");
    apb(1'b1, `REG_CTRL, 32'h3, 33'h0);
    wait_sb();
    apb(0, `REG_STAT, 0, 33'h34);
    apb(0, `REG_WREG, 0, 33'h81);
    apb(0, `REG_PC, 0, 33'd22);
    `CHK(prog_file_model_i.ram[7'h21], 8'h08)
    $display("Test call, return and bit ops done");
    for (int i = 0; i < 5; i++)
    begin
      a = rnd();
      k = (i == 2) ? a : rnd();
      pc = 22 + 3 * i;
      prog_file_model_i.rom[pc] = {6'h30, a};
      prog_file_model_i.rom[pc + 1] = {ops[i], k};
      prog_file_model_i.rom[pc + 2] = 14'h0063;
      case (i)
        0: r = a & k;
        1: r = a | k;
        2: r = a ^ k;
        3:
        begin
          {c, r} = a + k;
          dc = (a[3:0] + k[3:0]) > 5'd15;
        end
        default:
        begin
          r = k - a;
          c = k >= a;
          dc = k[3:0] >= a[3:0];
        end
      endcase
      apb(1'b1, `REG_CTRL, 32'h3, 33'h0);
      wait_sb();
      apb(0, `REG_WREG, 0, {25'h0, r});
      apb(0, `REG_STAT, 0, {27'h0, 3'b110, r == 8'h0, dc, c});
    end
    $display("Test literal ops done");
    print_verdict();
  end
endmodule
